/* core/boot_pkg.sv */
package boot_pkg;
	// ****************************************
	// link byte values
	// ****************************************
	localparam logic [7:0] MATCH1_A = 8'h86;
	localparam logic [7:0] MATCH1_B = 8'h30;
	localparam logic [7:0] MATCH2_A = 8'h79;
	localparam logic [7:0] MATCH2_B = 8'hcf;
	localparam logic [7:0] CMD_FLASH_READ = 8'h40;
	localparam logic [7:0] ERR_LINK = 8'ha1;
	localparam logic [7:0] ERR_BAD_CMD = 8'ha3;
	localparam logic [7:0] ERR_SPARE = 8'h63;
	localparam logic [7:0] BLANK_BYTE = 8'hff;
	localparam logic [7:0] PW_NONE = 8'h00;
	// ****************************************
	// memory map and counts
	// ****************************************
	localparam logic [23:0] MEM_SIZE = 24'h010000;
	localparam logic [23:0] PW_AREA_FIRST = 24'h00ffe0;
	localparam logic [23:0] PW_AREA_LAST = 24'h00ffff;
	localparam logic [23:0] COUNT_ZERO = 24'h000000;
	localparam logic [23:0] COUNT_ONE = 24'h000001;
	localparam logic [1:0] LAST_OF_THREE = 2'h2;
	localparam logic [2:0] LAST_OF_SIX = 3'h5;
	localparam int FIFO_DEPTH = 4;
	localparam int BYTE_W = 8;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int BYTE_GAP_NS = 20;
	localparam int BYTE_GAP_CYC = (BYTE_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] GAP_LOAD = 4'(BYTE_GAP_CYC);
endpackage

/* core/boot_link_if.sv */
`timescale 1ns/1ps
// byte-level view of the serial link, one strobe per received character
interface boot_link_if;
	logic [7:0] h2d_data;
	logic h2d_valid;
	logic h2d_err;
	logic [7:0] d2h_data;
	logic d2h_valid;
	logic d2h_ready;
	modport device (
		input h2d_data, h2d_valid, h2d_err, d2h_ready,
		output d2h_data, d2h_valid
	);
	modport ctrl (
		output h2d_data, h2d_valid, h2d_err, d2h_ready,
		input d2h_data, d2h_valid
	);
endinterface

/* core/boot_dev.sv */
`timescale 1ns/1ps
// ****************************************
// transmit buffer
// ****************************************
module boot_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;
	assign in_ready = cnt_q != FULL;
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rd_q];
	// pointers wrap naturally because depth is a power of two
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_q + AW'(do_wr);
			rd_q <= rd_q + AW'(do_rd);
			cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
	// storage has no reset, only valid entries are ever read
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_q] <= in_data;
		end
	end
endmodule // boot_fifo

// Functional notes
// - first match byte 0x86/0x30, echo or silence
// - calibrated rate holds for whole session
// - second match byte 0x79/0xCF, echo or silence
// - command 0x40 selects read, echoed
// - rejected command: three error bytes, idle
// - count storage address, three bytes, silent
// - comparison address then password, silent
// - blank top area skips password check
// - both addresses always sent; bad address idles
// - security or password error idles device
// - link error during password phase idles
// - after idle error controller resets device; boot_ctrl has no reset output, it stays busy or flags FAIL_OUT
// - read start address, three bytes, silent
// - byte count, three bytes, silent
// - zero or oversize count idles device
// - after checksum wait for next command
// - reserved command value idles device
module boot_dev
	import boot_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	boot_link_if.device link,
	input wire logic SECURE_IN,
	input wire logic [7:0] FLASH_DATA_IN,
	output logic [23:0] FLASH_ADDR_OUT,
	output logic FLASH_RD_OUT,
	output logic CAL_OUT,
	output logic IDLE_OUT
);
	typedef enum {S_CAL1, S_CAL2, S_CMD, S_ERRS, S_PCS, S_PCMP, S_CHK, S_BLANK, S_PWLEN,
		S_PWRX, S_PWCMP, S_RADDR, S_RCNT, S_CNTCHK, S_DPUSH, S_CKHI, S_CKLO, S_FWAIT,
		S_DEAD} dev_state_t;
	dev_state_t state_q, state_d, ret_q, ret_d;
	logic [23:0] sh_q, sh_d, pcs_q, pcs_d, pcmp_q, pcmp_d, addr_q, addr_d, cnt_q, cnt_d;
	logic [23:0] fa_q, fa_d;
	logic [15:0] sum_q, sum_d;
	logic [7:0] byte_q, byte_d, fd_q, fd_d, pwlen_q, pwlen_d, push_data;
	logic [1:0] idx_q, idx_d;
	logic blank_q, blank_d, cal_q, cal_d, frd_q, frd_d, push;
	logic fifo_ready, fifo_valid, fifo_take;
	logic [7:0] fifo_data;
	logic d2h_valid_q;
	logic [7:0] d2h_data_q;
	logic idle_q;

	// ****************************************
	// byte decode
	// ****************************************
	wire rx = link.h2d_valid;
	wire rx_ok = rx && !link.h2d_err;
	wire [23:0] sh_next = {sh_q[15:0], link.h2d_data};
	wire last3 = idx_q == LAST_OF_THREE;
	wire [1:0] idx_inc = idx_q + 2'h1;
	wire is_m1 = link.h2d_data == MATCH1_A || link.h2d_data == MATCH1_B;
	wire is_m2 = link.h2d_data == MATCH2_A || link.h2d_data == MATCH2_B;
	wire bad_addr = pcs_q >= MEM_SIZE || pcmp_q >= MEM_SIZE;
	wire bad_count = cnt_q == COUNT_ZERO || cnt_q > MEM_SIZE;

	// ****************************************
	// session sequencer
	// ****************************************
	// fetches are a two-cycle subroutine: address out, then capture and return
	always_comb begin
		state_d = state_q;
		ret_d = ret_q;
		sh_d = sh_q;
		pcs_d = pcs_q;
		pcmp_d = pcmp_q;
		addr_d = addr_q;
		cnt_d = cnt_q;
		fa_d = fa_q;
		sum_d = sum_q;
		byte_d = byte_q;
		fd_d = fd_q;
		pwlen_d = pwlen_q;
		idx_d = idx_q;
		blank_d = blank_q;
		cal_d = cal_q;
		frd_d = 1'b0;
		push = 1'b0;
		push_data = link.h2d_data;
		case (state_q)
			S_CAL1: if (rx_ok && is_m1) begin
				push = 1'b1;
				cal_d = 1'b1;
				state_d = S_CAL2;
			end
			S_CAL2: if (rx_ok && is_m2) begin
				push = 1'b1;
				state_d = S_CMD;
			end
			S_CMD: if (rx) begin
				idx_d = '0;
				if (rx_ok && link.h2d_data == CMD_FLASH_READ) begin
					push = 1'b1;
					state_d = S_PCS;
				end else begin
					byte_d = rx_ok ? ERR_BAD_CMD : ERR_LINK;
					state_d = S_ERRS;
				end
			end
			S_ERRS: begin
				push = 1'b1;
				push_data = byte_q;
				if (fifo_ready) begin
					idx_d = idx_inc;
					if (last3) state_d = S_DEAD;
				end
			end
			S_PCS, S_PCMP: if (rx) begin
				if (link.h2d_err) begin
					state_d = S_DEAD;
				end else begin
					sh_d = sh_next;
					idx_d = last3 ? 2'h0 : idx_inc;
					if (last3 && state_q == S_PCS) begin
						pcs_d = sh_next;
						state_d = S_PCMP;
					end else if (last3) begin
						pcmp_d = sh_next;
						state_d = S_CHK;
					end
				end
			end
			S_CHK: if (bad_addr || SECURE_IN) begin
				state_d = S_DEAD;
			end else begin
				addr_d = PW_AREA_FIRST;
				blank_d = 1'b1;
				fa_d = PW_AREA_FIRST;
				frd_d = 1'b1;
				ret_d = S_BLANK;
				state_d = S_FWAIT;
			end
			S_BLANK: begin
				frd_d = 1'b1;
				state_d = S_FWAIT;
				if (addr_q != PW_AREA_LAST) begin
					blank_d = blank_q && fd_q == BLANK_BYTE;
					addr_d = addr_q + COUNT_ONE;
					fa_d = addr_q + COUNT_ONE;
				end else if (blank_q && fd_q == BLANK_BYTE) begin
					frd_d = 1'b0;
					state_d = S_RADDR;
				end else begin
					fa_d = pcs_q;
					ret_d = S_PWLEN;
				end
			end
			S_PWLEN: begin
				pwlen_d = fd_q;
				state_d = fd_q == PW_NONE ? S_RADDR : S_PWRX;
			end
			S_PWRX: if (rx) begin
				if (link.h2d_err) begin
					state_d = S_DEAD;
				end else begin
					byte_d = link.h2d_data;
					fa_d = pcmp_q;
					pcmp_d = pcmp_q + COUNT_ONE;
					frd_d = 1'b1;
					ret_d = S_PWCMP;
					state_d = S_FWAIT;
				end
			end
			S_PWCMP: begin
				pwlen_d = pwlen_q - 8'h01;
				if (fd_q != byte_q) state_d = S_DEAD;
				else state_d = pwlen_q == 8'h01 ? S_RADDR : S_PWRX;
			end
			S_RADDR, S_RCNT: if (rx_ok) begin
				sh_d = sh_next;
				idx_d = last3 ? 2'h0 : idx_inc;
				if (last3 && state_q == S_RADDR) begin
					addr_d = sh_next;
					state_d = S_RCNT;
				end else if (last3) begin
					cnt_d = sh_next;
					state_d = S_CNTCHK;
				end
			end
			S_CNTCHK: if (bad_count) begin
				state_d = S_DEAD;
			end else begin
				sum_d = '0;
				fa_d = addr_q;
				frd_d = 1'b1;
				ret_d = S_DPUSH;
				state_d = S_FWAIT;
			end
			S_DPUSH: begin
				push = 1'b1;
				push_data = fd_q;
				if (fifo_ready) begin
					sum_d = sum_q + {8'h00, fd_q};
					cnt_d = cnt_q - COUNT_ONE;
					addr_d = addr_q + COUNT_ONE;
					fa_d = addr_q + COUNT_ONE;
					frd_d = cnt_q != COUNT_ONE;
					state_d = cnt_q == COUNT_ONE ? S_CKHI : S_FWAIT;
				end
			end
			S_CKHI: begin
				push = 1'b1;
				push_data = sum_q[15:8];
				if (fifo_ready) state_d = S_CKLO;
			end
			S_CKLO: begin
				push = 1'b1;
				push_data = sum_q[7:0];
				if (fifo_ready) state_d = S_CMD;
			end
			S_FWAIT: begin
				fd_d = FLASH_DATA_IN;
				state_d = ret_q;
			end
			default: state_d = S_DEAD; // only a reset leaves here
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state_q <= S_CAL1;
			ret_q <= S_CAL1;
			{sh_q, pcs_q, pcmp_q, addr_q, cnt_q, fa_q} <= '0;
			{sum_q, byte_q, fd_q, pwlen_q, idx_q} <= '0;
			{blank_q, cal_q, frd_q, idle_q} <= '0;
		end else begin
			state_q <= state_d;
			ret_q <= ret_d;
			{sh_q, pcs_q, pcmp_q, addr_q, cnt_q, fa_q} <= {sh_d, pcs_d, pcmp_d, addr_d, cnt_d, fa_d};
			{sum_q, byte_q, fd_q, pwlen_q, idx_q} <= {sum_d, byte_d, fd_d, pwlen_d, idx_d};
			{blank_q, cal_q, frd_q} <= {blank_d, cal_d, frd_d};
			idle_q <= state_d == S_DEAD;
		end
	end

	// ****************************************
	// transmit path
	// ****************************************
	// the output stage keeps link outputs on flops; it reloads when empty or taken
	assign fifo_take = !d2h_valid_q || link.d2h_ready;
	boot_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk(CLK_IN),
		.rst(RESET_IN),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_take),
		.out_data(fifo_data)
	);
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			d2h_valid_q <= 1'b0;
			d2h_data_q <= '0;
		end else if (fifo_take) begin
			d2h_valid_q <= fifo_valid;
			d2h_data_q <= fifo_data;
		end
	end
	assign link.d2h_valid = d2h_valid_q;
	assign link.d2h_data = d2h_data_q;
	assign FLASH_ADDR_OUT = fa_q;
	assign FLASH_RD_OUT = frd_q;
	assign CAL_OUT = cal_q;
	assign IDLE_OUT = idle_q;
endmodule // boot_dev

/* core/boot_ctrl.sv */
`timescale 1ns/1ps
module boot_ctrl
	import boot_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	boot_link_if.ctrl link,
	input wire logic START_IN,
	input wire logic [23:0] PCS_ADDR_IN,
	input wire logic [23:0] PCMP_ADDR_IN,
	input wire logic [23:0] RD_ADDR_IN,
	input wire logic [23:0] RD_COUNT_IN,
	input wire logic [7:0] PW_LEN_IN,
	input wire logic [7:0] PW_DATA_IN,
	input wire logic TX_ERR_IN,
	input wire logic RX_READY_IN,
	output logic PW_TAKE_OUT,
	output logic [7:0] RX_DATA_OUT,
	output logic RX_VALID_OUT,
	output logic [15:0] SUM_OUT,
	output logic DONE_OUT,
	output logic BUSY_OUT,
	output logic FAIL_OUT
);
	typedef enum {H_IDLE, H_SEND, H_GAP, H_ECHO, H_RXDATA, H_RXHI, H_RXLO, H_FAIL} ctrl_state_t;
	typedef enum {P_CAL1, P_CAL2, P_CMD, P_ADDR, P_PW, P_RADDR} ctrl_phase_t;
	ctrl_state_t st_q, st_d, nxt_q, nxt_d;
	ctrl_phase_t ph_q, ph_d;
	logic [47:0] pa_q, pa_d, ra_q, ra_d;
	logic [23:0] cnt_q, cnt_d;
	logic [15:0] sum_q, sum_d;
	logic [7:0] pwl_q, pwl_d, exp_q, exp_d, txd_q, txd_d, rxd_q, rxd_d, sel;
	logic [7:0] gap_q, gap_d;
	// the blank scan costs two cycles per top-area byte; the device ignores bytes meanwhile
	localparam logic [7:0] SCAN_GAP = 8'(2 * (PW_AREA_LAST - PW_AREA_FIRST + COUNT_ONE))
		+ 8'(GAP_LOAD);
	logic [2:0] idx_q, idx_d;
	logic cal_q, cal_d, txv_q, txv_d, txe_q, txe_d, rdy_q, take_q, take_d;
	logic rxv_q, rxv_d, done_q, done_d, busy_q, fail_q;

	// ****************************************
	// byte selection
	// ****************************************
	wire got = link.d2h_valid && rdy_q;
	// ready only where a byte is consumed, so none is lost while this side is busy sending
	wire rx_st = st_d == H_ECHO || st_d == H_RXDATA || st_d == H_RXHI || st_d == H_RXLO
		|| st_d == H_FAIL;
	wire last6 = idx_q == LAST_OF_SIX;
	assign sel = ph_q == P_CAL1 ? MATCH1_A :
		ph_q == P_CAL2 ? MATCH2_A :
		ph_q == P_CMD ? CMD_FLASH_READ :
		ph_q == P_ADDR ? pa_q[47:40] :
		ph_q == P_PW ? PW_DATA_IN : ra_q[47:40];

	// ****************************************
	// session sequencer
	// ****************************************
	// a silent device (idle after an error) leaves this side busy; timeout is the user's
	always_comb begin
		st_d = st_q;
		nxt_d = nxt_q;
		ph_d = ph_q;
		pa_d = pa_q;
		ra_d = ra_q;
		cnt_d = cnt_q;
		sum_d = sum_q;
		pwl_d = pwl_q;
		exp_d = exp_q;
		txd_d = txd_q;
		rxd_d = rxd_q;
		gap_d = gap_q;
		idx_d = idx_q;
		cal_d = cal_q;
		txe_d = txe_q;
		txv_d = 1'b0;
		take_d = 1'b0;
		rxv_d = 1'b0;
		done_d = 1'b0;
		case (st_q)
			H_IDLE: if (START_IN) begin
				pa_d = {PCS_ADDR_IN, PCMP_ADDR_IN};
				ra_d = {RD_ADDR_IN, RD_COUNT_IN};
				cnt_d = RD_COUNT_IN;
				pwl_d = PW_LEN_IN;
				idx_d = '0;
				ph_d = cal_q ? P_CMD : P_CAL1;
				st_d = H_SEND;
			end
			H_SEND: begin
				txd_d = sel;
				txv_d = 1'b1;
				txe_d = TX_ERR_IN;
				exp_d = sel;
				gap_d = 8'(GAP_LOAD);
				st_d = H_GAP;
				nxt_d = H_SEND;
				case (ph_q)
					P_CAL1, P_CAL2, P_CMD: nxt_d = H_ECHO;
					P_ADDR: begin
						pa_d = {pa_q[39:0], 8'h00};
						idx_d = last6 ? 3'h0 : idx_q + 3'h1;
						if (last6) begin
							ph_d = pwl_q == PW_NONE ? P_RADDR : P_PW;
							gap_d = SCAN_GAP;
						end
					end
					P_PW: begin
						take_d = 1'b1;
						pwl_d = pwl_q - 8'h01;
						if (pwl_q == 8'h01) ph_d = P_RADDR;
					end
					default: begin
						ra_d = {ra_q[39:0], 8'h00};
						idx_d = idx_q + 3'h1;
						if (last6) nxt_d = H_RXDATA;
					end
				endcase
			end
			// spacing lets the device finish a flash fetch between bytes
			H_GAP: begin
				gap_d = gap_q - 8'h01;
				if (gap_q == 8'h01) st_d = nxt_q;
			end
			H_ECHO: if (got) begin
				if (link.d2h_data != exp_q) begin
					st_d = H_FAIL;
				end else begin
					st_d = H_SEND;
					cal_d = 1'b1;
					ph_d = ph_q == P_CAL1 ? P_CAL2 : ph_q == P_CAL2 ? P_CMD : P_ADDR;
				end
			end
			H_RXDATA: if (got) begin
				rxd_d = link.d2h_data;
				rxv_d = 1'b1;
				cnt_d = cnt_q - COUNT_ONE;
				if (cnt_q == COUNT_ONE) st_d = H_RXHI;
			end
			H_RXHI: if (got) begin
				sum_d = {link.d2h_data, 8'h00};
				st_d = H_RXLO;
			end
			H_RXLO: if (got) begin
				sum_d = {sum_q[15:8], link.d2h_data};
				done_d = 1'b1;
				st_d = H_IDLE;
			end
			default: st_d = H_FAIL;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			st_q <= H_IDLE;
			nxt_q <= H_IDLE;
			ph_q <= P_CAL1;
			{pa_q, ra_q, cnt_q, sum_q, pwl_q, exp_q, txd_q, rxd_q} <= '0;
			{gap_q, idx_q, cal_q, txv_q, txe_q, rdy_q, take_q} <= '0;
			{rxv_q, done_q, busy_q, fail_q} <= '0;
		end else begin
			st_q <= st_d;
			nxt_q <= nxt_d;
			ph_q <= ph_d;
			{pa_q, ra_q, cnt_q, sum_q, pwl_q} <= {pa_d, ra_d, cnt_d, sum_d, pwl_d};
			{exp_q, txd_q, rxd_q, gap_q, idx_q} <= {exp_d, txd_d, rxd_d, gap_d, idx_d};
			{cal_q, txv_q, txe_q, take_q, rxv_q, done_q} <= {cal_d, txv_d, txe_d, take_d, rxv_d, done_d};
			rdy_q <= RX_READY_IN && rx_st;
			busy_q <= st_d != H_IDLE && st_d != H_FAIL;
			fail_q <= st_d == H_FAIL;
		end
	end

	assign link.h2d_data = txd_q;
	assign link.h2d_valid = txv_q;
	assign link.h2d_err = txe_q;
	assign link.d2h_ready = rdy_q;
	assign PW_TAKE_OUT = take_q;
	assign RX_DATA_OUT = rxd_q;
	assign RX_VALID_OUT = rxv_q;
	assign SUM_OUT = sum_q;
	assign DONE_OUT = done_q;
	assign BUSY_OUT = busy_q;
	assign FAIL_OUT = fail_q;
endmodule // boot_ctrl

/* bench/boot_link_asserts.sv */
`timescale 1ns/1ps
// ********
// link checker
// ********
module boot_link_asserts
	import boot_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	input wire logic [7:0] h2d_data,
	input wire logic h2d_valid,
	input wire logic h2d_err,
	input wire logic [7:0] d2h_data,
	input wire logic d2h_valid,
	input wire logic d2h_ready
);
	logic [5:0] nbytes_q;
	logic [2:0] errs_q;
	wire taken = d2h_valid && d2h_ready;
	// byte index saturates so later sessions never alias the opening bytes
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			nbytes_q <= 6'h00;
			errs_q <= 3'h0;
		end else begin
			if (h2d_valid && nbytes_q != 6'h3f) nbytes_q <= nbytes_q + 6'h01;
			if (taken && nbytes_q == 6'h03 && d2h_data == ERR_LINK) errs_q <= errs_q + 3'h1;
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	// ready stays low through the send gap, so each echo is still held three to four cycles on
	a_first_echo: assert property (h2d_valid && nbytes_q == 6'h00 && h2d_data == MATCH1_A
		|-> ##[3:4] (d2h_valid && d2h_data == MATCH1_A)) else $error("first byte not echoed");
	a_second_echo: assert property (h2d_valid && nbytes_q == 6'h01 && h2d_data == MATCH2_A
		|-> ##[3:4] (d2h_valid && d2h_data == MATCH2_A)) else $error("second byte not echoed");
	a_cmd_echo: assert property (h2d_valid && !h2d_err && nbytes_q == 6'h02
		|-> ##[3:4] (d2h_valid && d2h_data == CMD_FLASH_READ)) else $error("command not echoed");
	a_silent_addr: assert property (h2d_valid && nbytes_q >= 6'h03 && nbytes_q <= 6'h0d
		&& errs_q == 3'h0 |-> !d2h_valid [*4]) else $error("reply to address byte");
	a_no_early: assert property (d2h_valid |-> nbytes_q != 6'h00) else $error("talks first");
	a_valid_hold: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
		else $error("byte dropped before taken");
	a_err_code: assert property (h2d_valid && h2d_err && nbytes_q == 6'h02
		|-> ##[3:4] (d2h_valid && d2h_data == ERR_LINK)) else $error("no link error code");
	a_err_triple: assert property (h2d_valid && h2d_err && nbytes_q == 6'h02
		|-> ##[4:60] errs_q == 3'h3) else $error("error code not sent three times");
	a_err_stop: assert property (errs_q == 3'h3 |-> ##2 !d2h_valid) else $error("talks after error");
endmodule // boot_link_asserts

/* bench/test_boot_serial_flash_read_cmd.sv */
`timescale 1ns/1ps
module test_boot_serial_flash_read_cmd
	import boot_pkg::*;
;
	// ********
	// stimulus state
	// ********
	logic clk, rst = 1'b1, start = 1'b0, secure = 1'b0, tx_err = 1'b0, rx_ready = 1'b1;
	logic stall = 1'b0, b_ready = 1'b1;
	logic [23:0] pcs = 24'h0, pcmp = 24'h000f00, rd_addr = 24'h0, rd_cnt = 24'h0;
	logic [7:0] pw_len = 8'h0, pw_flip = 8'h0, pw_sel = 8'h0, h2d_n = 8'h0, err_at = 8'hff;
	logic [15:0] sum_seen;
	wire [7:0] pw_data, flash_data, flash_data_b, rx_data;
	wire [23:0] flash_addr, flash_addr_b;
	wire cal, idle, idle_b, pw_take, rx_valid, done, fail;
	wire flash_rd, flash_rd_b, busy;
	wire [15:0] sum;
	logic [7:0] mem [0:65535];
	logic [7:0] rxq[$], q2[$];
	int err_count = 0, compares = 0, cyc = 0, done_cnt = 0;
	boot_link_if link();
	boot_link_if link_b();
	boot_dev boot_dev_inst (.CLK_IN(clk), .RESET_IN(rst), .link(link), .SECURE_IN(secure),
		.FLASH_DATA_IN(flash_data), .FLASH_ADDR_OUT(flash_addr), .FLASH_RD_OUT(flash_rd),
		.CAL_OUT(cal), .IDLE_OUT(idle));
	// second device faces the bench, which breaks the link order on purpose
	boot_dev boot_dev_inst_b (.CLK_IN(clk), .RESET_IN(rst), .link(link_b), .SECURE_IN(1'b0),
		.FLASH_DATA_IN(flash_data_b), .FLASH_ADDR_OUT(flash_addr_b), .FLASH_RD_OUT(flash_rd_b),
		.CAL_OUT(), .IDLE_OUT(idle_b));
	boot_ctrl boot_ctrl_inst (.CLK_IN(clk), .RESET_IN(rst), .link(link), .START_IN(start),
		.PCS_ADDR_IN(pcs), .PCMP_ADDR_IN(pcmp), .RD_ADDR_IN(rd_addr), .RD_COUNT_IN(rd_cnt),
		.PW_LEN_IN(pw_len), .PW_DATA_IN(pw_data), .TX_ERR_IN(tx_err), .RX_READY_IN(rx_ready),
		.PW_TAKE_OUT(pw_take), .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid), .SUM_OUT(sum),
		.DONE_OUT(done), .BUSY_OUT(busy), .FAIL_OUT(fail));
	boot_link_asserts boot_link_asserts_inst (.CLK_IN(clk), .RESET_IN(rst),
		.h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid), .h2d_err(link.h2d_err),
		.d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));
	// flash is read combinationally; the password source follows the compare area
	// outside a read strobe the flash shows the inverse, so a mistimed capture is caught
	assign flash_data = flash_rd ? mem[flash_addr[15:0]] : ~mem[flash_addr[15:0]];
	assign flash_data_b = flash_rd_b ? mem[flash_addr_b[15:0]] : ~mem[flash_addr_b[15:0]];
	assign pw_data = mem[pcmp[15:0] + 16'(pw_sel)] ^ pw_flip;
	assign link_b.d2h_ready = b_ready;
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ********
	// monitors
	// ********
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rx_valid) rxq.push_back(rx_data);
		if (done) done_cnt++;
		if (done) sum_seen = sum;
		if (link_b.d2h_valid && link_b.d2h_ready) q2.push_back(link_b.d2h_data);
		if (link.h2d_valid) h2d_n <= h2d_n + 8'h01;
		if (pw_take) pw_sel <= pw_sel + 8'h01;
		if (cyc == 30000) begin
			err_count++;
			end_of_test();
		end
	end
	// error flag follows the byte index; stall toggles ready as a slow far side
	always @(negedge clk) begin
		tx_err <= (h2d_n == err_at);
		rx_ready <= stall ? ~rx_ready : 1'b1;
	end
	// ********
	// tasks
	// ********
	task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task reset_all;
		@(negedge clk);
		rst = 1'b1;
		h2d_n = 8'h00;
		q2.delete();
		repeat (2) @(negedge clk);
		rst = 1'b0;
	endtask
	task session(input logic [23:0] a, input logic [23:0] n, input logic [23:0] cs, input logic ok);
		logic [15:0] s;
		s = 16'h0000;
		rxq.delete();
		done_cnt = 0;
		@(negedge clk);
		rd_addr = a;
		rd_cnt = n;
		pcs = cs;
		pw_sel = 8'h00;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		chk("busy", 1'b1, busy);
		for (int i = 0; i < 4000 && done_cnt == 0 && idle !== 1'b1; i++) @(negedge clk);
		repeat (40) @(negedge clk);
		chk("idle", !ok, idle);
		chk("done count", ok, done_cnt);
		if (ok) begin
			chk("byte count", n, rxq.size());
			for (int i = 0; i < n; i++) begin
				chk("data", mem[a[15:0] + 16'(i)], rxq[i]);
				s = s + 16'(mem[a[15:0] + 16'(i)]);
			end
			chk("checksum", s, sum_seen);
			chk("busy after", 1'b0, busy);
		end
	endtask
	task put_b(input logic [7:0] b);
		@(negedge clk);
		link_b.h2d_data = b;
		link_b.h2d_valid = 1'b1;
		@(negedge clk);
		link_b.h2d_valid = 1'b0;
		repeat (10) @(negedge clk);
	endtask
	// ********
	// scenarios
	// ********
	task t_blank_read;
		reset_all();
		session(24'h000123, 24'h000005, 24'h00fff0, 1'b1);
		chk("calibrated", 1'b1, cal);
		stall = 1'b1;
		session(24'h00fffe, 24'h000002, 24'h00fff0, 1'b1);
		stall = 1'b0;
	endtask
	task t_refusals;
		reset_all();
		session(24'h0, 24'h000000, 24'h00fff0, 1'b0);
		reset_all();
		session(24'h0, 24'h010001, 24'h00fff0, 1'b0);
		reset_all();
		session(24'h0, 24'h000004, 24'h010000, 1'b0);
		secure = 1'b1;
		reset_all();
		session(24'h0, 24'h000004, 24'h00fff0, 1'b0);
		secure = 1'b0;
	endtask
	// a written top area forces the password compare
	task t_password;
		mem[16'hffe0] = 8'h00;
		mem[16'hfff0] = 8'h02;
		pw_len = 8'h02;
		reset_all();
		session(24'h000020, 24'h000003, 24'h00fff0, 1'b1);
		pw_flip = 8'h01;
		reset_all();
		session(24'h000020, 24'h000003, 24'h00fff0, 1'b0);
		pw_flip = 8'h00;
		pw_len = 8'h00;
		mem[16'hffe0] = 8'hff;
		mem[16'hfff0] = 8'hff;
	endtask
	task t_link_err;
		err_at = 8'h04;
		reset_all();
		session(24'h0, 24'h000004, 24'h00fff0, 1'b0);
		err_at = 8'h02;
		reset_all();
		session(24'h0, 24'h000004, 24'h00fff0, 1'b0);
		chk("fail flag", 1'b1, fail);
		err_at = 8'hff;
	endtask
	// bad match bytes get silence, a reserved command gets three codes then nothing;
	// with the reader held off, all five replies must wait in order, four in the buffer and the first in the output stage
	task t_far_faults(input logic hold);
		logic [7:0] exp_b [5];
		exp_b = '{MATCH1_B, MATCH2_B, ERR_BAD_CMD, ERR_BAD_CMD, ERR_BAD_CMD};
		reset_all();
		b_ready = !hold;
		put_b(8'h55);
		put_b(MATCH1_B);
		put_b(8'h12);
		put_b(MATCH2_B);
		put_b(8'h55);
		put_b(CMD_FLASH_READ);
		if (hold) begin
			chk("far held valid", 1'b1, link_b.d2h_valid);
			chk("far held byte", MATCH1_B, link_b.d2h_data);
			chk("far count held", 24'h0, q2.size());
			b_ready = 1'b1;
			repeat (10) @(negedge clk);
		end
		chk("far count", 24'h5, q2.size());
		for (int i = 0; i < 5; i++) chk("far byte", exp_b[i], q2[i]);
		chk("far idle", 1'b1, idle_b);
		chk("far drained", 1'b0, link_b.d2h_valid);
	endtask
	task end_of_test;
		if (err_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		link_b.h2d_data = 8'h00;
		link_b.h2d_valid = 1'b0;
		link_b.h2d_err = 1'b0;
		for (int i = 0; i < 65536; i++) mem[i] = (i >= 16'hffe0) ? BLANK_BYTE : 8'(i * 7 + 3);
		t_blank_read();
		t_refusals();
		t_password();
		t_link_err();
		t_far_faults(1'b0);
		t_far_faults(1'b1);
		end_of_test();
	end
endmodule // test_boot_serial_flash_read_cmd
